// ==== hdl/ises_pkg.sv ====
// Summary of operation
// R01 - below the supply trigger the device sits in reset; above it, standby.
// R02 - sample data on clock rise, change it on clock fall, drive open drain.
// R03 - undriven strap and write-protect inputs count as low.
// R04 - data falling with clock high is START; data rising is STOP.
// R05 - master keeps data stable while clock is high and starts only when idle.
// R06 - all bus activity is ignored until a START is seen.
// R07 - address byte: fixed 1010, three strap bits, then read/write bit.
// R08 - acknowledge matching address, memory-address and data bytes on clock 9.
// R09 - in read mode send a byte, release on clock 9, continue while acked.
// R10 - master ends a read with no acknowledge followed by STOP.
// R11 - two address bytes load the counter: 2 ignored, 8 page, 6 byte bits.
// R12 - data bytes fill the page buffer; STOP starts the internal write.
// R13 - while writing: data floats, requests ignored, address not acknowledged.
// R14 - up to 64 bytes per page; byte index wraps, page stays latched.
// R15 - wrapped bytes overwrite; only the latest loaded locations are written.
// R16 - write-protect is sampled on the last clock fall before first data.
// R17 - protected write: first data byte not acked, whole request dropped.
// R18 - an unwritten device reads FFh at every location.
// R19 - read address without address load returns the current counter byte.
// R20 - address bytes then new START with read address gives a selective read.
// R21 - sequential read increments the address and wraps at end of memory.
// R22 - unacknowledged read byte then STOP returns the device to standby.
// R23 - an internal counter times the write; busy clears when it expires.
// R24 - after a write the counter holds the next address within the page.
package ises_pkg;
    localparam logic [3:0] DEV_TYPE = 4'hA;
    localparam int MEM_AW = 14;
    localparam int MEM_BYTES = 16384;
    localparam int PAGE_AW = 6;
    localparam int PAGE_BYTES = 64;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam int CLK_FREQ_MHZ = 50;
    localparam int INTERNAL_WRITE_TIME_US = 5000;
    // longest time, exact multiple of the clock period
    localparam int INTERNAL_WRITE_CYCLES =
        INTERNAL_WRITE_TIME_US * CLK_FREQ_MHZ;
    localparam int WCNT_W = 18;
    // pin vector layout inside the synchroniser
    localparam int PIN_W = 7;
    localparam int PIN_SCL = 0;
    localparam int PIN_SDA = 1;
    localparam int PIN_WP = 2;
    localparam int PIN_STRAP = 3;
    localparam int PIN_SUPPLY = 6;
    // idle bus high, straps, protect and supply low
    localparam logic [PIN_W-1:0] PIN_RST = 7'h03;
endpackage : ises_pkg

// ==== hdl/ises_line_if.sv ====
`timescale 1ns/1ns
interface ises_line_if;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    logic sda;
    logic wp;
    logic supply_ok;
    logic [2:0] strap;
    modport det (
        output scl_rise, scl_fall, start, stop, sda, wp, supply_ok, strap
    );
    modport core (
        input scl_rise, scl_fall, start, stop, sda, wp, supply_ok, strap
    );
endinterface : ises_line_if

// ==== hdl/ises_pin_sync.sv ====
`timescale 1ns/1ns
module ises_pin_sync import ises_pkg::*; (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [PIN_W-1:0] pin_in,
    ises_line_if.det line
);
    typedef struct packed {
        logic [PIN_W-1:0] s1;
        logic [PIN_W-1:0] s2;
        logic [PIN_W-1:0] s3;
        logic [PIN_W-1:0] lvl;
        logic scl_rise;
        logic scl_fall;
        logic start;
        logic stop;
    } ises_sync_t;

    ises_sync_t s_r;
    ises_sync_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.s1 = pin_in;
        s_nxt.s2 = s_r.s1;
        s_nxt.s3 = s_r.s2;
        // a level change counts only once stages two and three agree
        s_nxt.lvl = (~(s_r.s2 ^ s_r.s3) & s_r.s3) |
                    ((s_r.s2 ^ s_r.s3) & s_r.lvl);
        s_nxt.scl_rise = !s_r.lvl[PIN_SCL] && s_nxt.lvl[PIN_SCL];
        s_nxt.scl_fall = s_r.lvl[PIN_SCL] && !s_nxt.lvl[PIN_SCL];
        s_nxt.start = s_r.lvl[PIN_SCL] && s_nxt.lvl[PIN_SCL] &&
                      s_r.lvl[PIN_SDA] && !s_nxt.lvl[PIN_SDA]; // R04
        s_nxt.stop = s_r.lvl[PIN_SCL] && s_nxt.lvl[PIN_SCL] &&
                     !s_r.lvl[PIN_SDA] && s_nxt.lvl[PIN_SDA]; // R04
    end

    // straps and protect reset low, matching the pad pull-downs
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            s_r <= '{s1: PIN_RST, s2: PIN_RST, s3: PIN_RST, // R03
                     lvl: PIN_RST, default: '0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign line.scl_rise = s_r.scl_rise;
    assign line.scl_fall = s_r.scl_fall;
    assign line.start = s_r.start;
    assign line.stop = s_r.stop;
    assign line.sda = s_r.lvl[PIN_SDA];
    assign line.wp = s_r.lvl[PIN_WP];
    assign line.supply_ok = s_r.lvl[PIN_SUPPLY];
    assign line.strap = s_r.lvl[PIN_STRAP+2:PIN_STRAP];
endmodule : ises_pin_sync

// ==== hdl/ises_mem_array.sv ====
`timescale 1ns/1ns
module ises_mem_array import ises_pkg::*; (
    input wire logic mclk,
    input wire logic wr_en,
    input wire logic [MEM_AW-1:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic [MEM_AW-1:0] rd_addr,
    output logic [7:0] rd_data
);
    // stands in for the nonvolatile cells: never cleared by reset
    logic [7:0] mem [MEM_BYTES];

    initial begin
        for (int i = 0; i < MEM_BYTES; i++) begin
            mem[i] = ERASED_BYTE; // R18
        end
    end

    always_ff @(posedge mclk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    assign rd_data = mem[rd_addr];
endmodule : ises_mem_array

// ==== hdl/ises_eeprom.sv ====
`timescale 1ns/1ns
module ises_eeprom import ises_pkg::*; #(
    parameter int unsigned WRITE_CYCLES = INTERNAL_WRITE_CYCLES
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic supply_above_por,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic chip_select_strap_0,
    input wire logic chip_select_strap_1,
    input wire logic chip_select_strap_2,
    input wire logic wp_in
);
    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_DEVADDR = 7'h02,
        ST_ADDRHI = 7'h04,
        ST_ADDRLO = 7'h08,
        ST_WDATA = 7'h10,
        ST_RDATA = 7'h20,
        ST_SKIP = 7'h40
    } ises_state_t;

    typedef struct packed {
        ises_state_t st;
        logic [3:0] bitcnt;
        logic in_ack;
        logic drv_low;
        logic [7:0] shreg;
        logic [MEM_AW-1:0] addr;
        logic [5:0] hi;
        logic wp_lat;
        logic busy;
        logic [WCNT_W-1:0] wcnt;
        logic [PAGE_AW:0] cidx;
        logic [7:0] cpage;
        logic [PAGE_BYTES-1:0] valid;
        logic [PAGE_BYTES-1:0][7:0] pbuf;
    } ises_core_t;

    localparam ises_core_t CORE_RST = '{st: ST_IDLE, default: '0};
    localparam logic [WCNT_W-1:0] WC_LAST = WCNT_W'(WRITE_CYCLES - 1);

    ises_line_if line ();

    ises_core_t s_r;
    ises_core_t s_nxt;
    logic [7:0] rd_data;
    logic wr_en;
    logic [MEM_AW-1:0] wr_addr;
    logic [7:0] wr_data;
    logic byte_end;
    logic [7:0] rx;

    ises_pin_sync u_sync (
        .mclk(mclk),
        .rstn(rstn),
        .pin_in({supply_above_por, chip_select_strap_2,
                 chip_select_strap_1, chip_select_strap_0,
                 wp_in, sda_in, scl_in}),
        .line(line.det)
    );

    ises_mem_array u_mem (
        .mclk(mclk),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .rd_addr(s_r.addr),
        .rd_data(rd_data)
    );

    // commit walks the page buffer once, one byte per clock
    assign wr_en = s_r.busy && !s_r.cidx[PAGE_AW] &&
                   s_r.valid[s_r.cidx[PAGE_AW-1:0]]; // R15
    assign wr_addr = {s_r.cpage, s_r.cidx[PAGE_AW-1:0]};
    assign wr_data = s_r.pbuf[s_r.cidx[PAGE_AW-1:0]];

    assign byte_end = line.scl_fall && !s_r.in_ack &&
                      s_r.bitcnt == BYTE_BITS;
    assign rx = s_r.shreg;

    always_comb begin
        s_nxt = s_r;
        if (!line.supply_ok) begin
            s_nxt = CORE_RST; // R01
        end else begin
            if (s_r.busy) begin
                if (!s_r.cidx[PAGE_AW]) begin
                    s_nxt.cidx = s_r.cidx + 7'h01;
                end
                if (s_r.wcnt == WC_LAST) begin
                    s_nxt.busy = 1'b0; // R23
                    s_nxt.valid = '0;
                end else begin
                    s_nxt.wcnt = s_r.wcnt + 18'h00001;
                end
            end
            if (line.start) begin
                s_nxt.st = ST_DEVADDR; // R06
                s_nxt.bitcnt = 4'h0;
                s_nxt.in_ack = 1'b0;
                s_nxt.drv_low = 1'b0;
                if (!s_r.busy) begin
                    s_nxt.valid = '0; // R15
                end
            end else if (line.stop) begin
                if (s_r.st == ST_WDATA && s_r.valid != '0 && !s_r.busy) begin
                    s_nxt.busy = 1'b1; // R12
                    s_nxt.wcnt = '0;
                    s_nxt.cidx = '0;
                    s_nxt.cpage = s_r.addr[MEM_AW-1:PAGE_AW];
                end
                s_nxt.st = ST_IDLE; // R22
                s_nxt.drv_low = 1'b0;
                s_nxt.in_ack = 1'b0;
                // a stale count would make a stray idle fall look like a byte
                s_nxt.bitcnt = 4'h0; // R06
            end else if (line.scl_rise) begin
                if (s_r.st == ST_RDATA) begin
                    if (s_r.in_ack && line.sda) begin
                        s_nxt.st = ST_SKIP; // R09
                    end
                end else if (s_r.st != ST_IDLE && s_r.st != ST_SKIP &&
                             !s_r.in_ack) begin
                    s_nxt.shreg = {s_r.shreg[6:0], line.sda}; // R02
                    s_nxt.bitcnt = s_r.bitcnt + 4'h1;
                end
            end else if (line.scl_fall) begin
                if (s_r.st == ST_RDATA) begin
                    if (s_r.in_ack) begin
                        // ack phase over: load and present the msb
                        s_nxt.shreg = rd_data; // R19
                        s_nxt.drv_low = ~rd_data[7]; // R02
                        s_nxt.bitcnt = 4'h1;
                        s_nxt.in_ack = 1'b0;
                    end else if (s_r.bitcnt != BYTE_BITS) begin
                        s_nxt.shreg = {s_r.shreg[6:0], 1'b0};
                        s_nxt.drv_low = ~s_r.shreg[6];
                        s_nxt.bitcnt = s_r.bitcnt + 4'h1;
                    end else begin
                        s_nxt.drv_low = 1'b0; // R09
                        s_nxt.in_ack = 1'b1;
                        s_nxt.addr = s_r.addr + 14'h0001; // R21
                    end
                end else if (s_r.in_ack) begin
                    s_nxt.drv_low = 1'b0;
                    s_nxt.in_ack = 1'b0;
                    s_nxt.bitcnt = 4'h0;
                    // last fall before the first data byte
                    if (s_r.st == ST_WDATA && s_r.valid == '0) begin
                        s_nxt.wp_lat = line.wp; // R16
                    end
                end else if (s_r.bitcnt == BYTE_BITS) begin
                    case (s_r.st)
                        ST_DEVADDR: begin
                            if (rx[7:4] == DEV_TYPE && // R07
                                rx[3:1] == line.strap && !s_r.busy) begin
                                s_nxt.drv_low = 1'b1; // R08
                                s_nxt.in_ack = 1'b1;
                                s_nxt.st = rx[0] ? ST_RDATA : ST_ADDRHI;
                            end else begin
                                s_nxt.st = ST_SKIP; // R13
                            end
                        end
                        ST_ADDRHI: begin
                            s_nxt.hi = rx[5:0]; // R11
                            s_nxt.drv_low = 1'b1; // R08
                            s_nxt.in_ack = 1'b1;
                            s_nxt.st = ST_ADDRLO;
                        end
                        ST_ADDRLO: begin
                            s_nxt.addr = {s_r.hi, rx}; // R20
                            s_nxt.drv_low = 1'b1; // R08
                            s_nxt.in_ack = 1'b1;
                            s_nxt.st = ST_WDATA;
                        end
                        ST_WDATA: begin
                            if (s_r.wp_lat) begin
                                s_nxt.st = ST_SKIP; // R17
                                s_nxt.valid = '0;
                            end else begin
                                s_nxt.pbuf[s_r.addr[PAGE_AW-1:0]] = rx;
                                s_nxt.valid[s_r.addr[PAGE_AW-1:0]] = 1'b1;
                                // page number held, byte index wraps
                                s_nxt.addr[PAGE_AW-1:0] =
                                    s_r.addr[PAGE_AW-1:0] + 6'h01; // R14 R24
                                s_nxt.drv_low = 1'b1; // R08
                                s_nxt.in_ack = 1'b1;
                            end
                        end
                        default: begin
                            s_nxt.st = ST_SKIP;
                        end
                    endcase
                end
            end
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            s_r <= CORE_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // open drain: only ever pull low, released while busy
    assign sda_out = 1'b0; // R02
    assign sda_oe = s_r.drv_low && !s_r.busy; // R13

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);

    por_hold_a: // R01
    assert property (!line.supply_ok |=>
        s_r.st == ST_IDLE && !s_r.busy && !sda_oe)
        else $error("reset state not held below supply trigger");

    start_take_a: // R04
    assert property (line.supply_ok && line.start |=>
        s_r.st == ST_DEVADDR && s_r.bitcnt == 4'h0 && !sda_oe)
        else $error("start not taken");

    idle_ignore_a: // R06
    assert property (s_r.st == ST_IDLE && !line.start |=>
        s_r.st == ST_IDLE && !sda_oe)
        else $error("activity before start not ignored");

    addr_nak_a: // R07
    assert property (line.supply_ok && byte_end && s_r.st == ST_DEVADDR &&
        (s_r.shreg[7:4] != DEV_TYPE || s_r.shreg[3:1] != line.strap) |=>
        s_r.st == ST_SKIP && !sda_oe)
        else $error("foreign address acknowledged");

    ack_hold_a: // R08
    assert property (line.supply_ok && byte_end &&
        s_r.st == ST_ADDRHI |=> sda_oe && s_r.in_ack &&
        s_r.st == ST_ADDRLO)
        else $error("address byte not acknowledged");

    busy_nak_a: // R13
    assert property (line.supply_ok && byte_end &&
        s_r.st == ST_DEVADDR && s_r.busy |=>
        !sda_oe && s_r.st == ST_SKIP)
        else $error("address acknowledged during write cycle");

    wp_reject_a: // R17
    assert property (line.supply_ok && byte_end &&
        s_r.st == ST_WDATA && s_r.wp_lat |=>
        s_r.st == ST_SKIP && s_r.valid == '0 && !sda_oe)
        else $error("protected write not rejected");

    page_wrap_a: // R14
    assert property (line.supply_ok && byte_end &&
        s_r.st == ST_WDATA && !s_r.wp_lat |=>
        s_r.addr[MEM_AW-1:PAGE_AW] == $past(s_r.addr[MEM_AW-1:PAGE_AW])
        && s_r.addr[PAGE_AW-1:0] == $past(s_r.addr[PAGE_AW-1:0]) + 6'h01)
        else $error("page address not wrapped in page");

    seq_wrap_a: // R21
    assert property (line.supply_ok && line.scl_fall &&
        s_r.st == ST_RDATA && !s_r.in_ack &&
        s_r.bitcnt == BYTE_BITS |=>
        s_r.addr == $past(s_r.addr) + 14'h0001 && !sda_oe)
        else $error("read address not advanced");

    nak_end_a: // R22
    assert property (line.supply_ok && line.scl_rise &&
        s_r.st == ST_RDATA && s_r.in_ack && line.sda |=>
        s_r.st == ST_SKIP ##1 !sda_oe)
        else $error("read continued after no acknowledge");

    wr_start_a: // R12
    assert property (line.supply_ok && line.stop &&
        s_r.st == ST_WDATA && s_r.valid != '0 && !s_r.busy |=>
        s_r.busy && s_r.wcnt == '0 && s_r.st == ST_IDLE)
        else $error("stop did not start write cycle");

    busy_len_a: // R23
    assert property (line.supply_ok && s_r.busy &&
        s_r.wcnt != WC_LAST |=> s_r.busy)
        else $error("write cycle ended early");

    rd_load_a: // R19
    assert property (line.supply_ok && line.scl_fall &&
        s_r.st == ST_RDATA && s_r.in_ack |=>
        s_r.shreg == $past(rd_data) && sda_oe == !$past(rd_data[7]))
        else $error("read byte not taken from current address");

    addr_load_a: // R20
    assert property (line.supply_ok && byte_end && s_r.st == ST_ADDRLO |=>
        s_r.addr == {$past(s_r.hi), $past(s_r.shreg)} && s_r.st == ST_WDATA)
        else $error("memory address not loaded");

    wp_sample_a: // R16
    assert property (line.supply_ok && line.scl_fall && s_r.in_ack &&
        s_r.st == ST_WDATA && s_r.valid == '0 |=>
        s_r.wp_lat == $past(line.wp))
        else $error("protect level not sampled before first data");
endmodule : ises_eeprom

// ==== tb/ises_master.sv ====
`timescale 1ns/1ns
module ises_master (
    input wire logic mclk,
    input wire logic sda,
    output logic scl,
    output logic sda_low
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask : tick

    // a start from idle or repeated; sda released while scl is low, then pulled low while scl is high
    task automatic start();
        sda_low <= 1'b0;
        tick(8);
        scl <= 1'b1;
        tick(10);
        sda_low <= 1'b1;
        tick(10);
        scl <= 1'b0;
        tick(8);
    endtask : start

    task automatic stop();
        sda_low <= 1'b1;
        tick(8);
        scl <= 1'b1;
        tick(10);
        sda_low <= 1'b0;
        tick(10);
    endtask : stop

    // sda set 8 cycles clear of either scl edge, sampled just before fall
    task automatic clk_bit(input logic b, output logic r);
        sda_low <= !b;
        tick(8);
        scl <= 1'b1;
        tick(10);
        r = sda;
        scl <= 1'b0;
        tick(8);
    endtask : clk_bit

    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(d[i], r);
        end
        clk_bit(1'b1, r);
        ack = !r;
    endtask : wbyte

    task automatic rbyte(input logic more, output logic [7:0] d);
        logic r;
        for (int i = 0; i < 8; i++) begin
            clk_bit(1'b1, r);
            d = {d[6:0], r};
        end
        clk_bit(!more, r);
    endtask : rbyte
endmodule : ises_master

// ==== tb/ises_eeprom_test.sv ====
`timescale 1ns/1ns
module ises_eeprom_test import ises_pkg::*;;
    localparam int WCY = 1000;
    localparam logic [2:0] STRAP = 3'h5;
    logic mclk, rstn, supply, wp, sda_out, sda_oe, scl, sda_low, sda;
    logic [2:0] strap;
    logic oe_q = 1'b0;
    logic scl_q = 1'b1;
    int n_fail = 0;
    int total_checks = 0;
    int cyc = 0;

    // pulled-up wire, low if either party pulls
    assign sda = (sda_oe ? sda_out : 1'b1) & !sda_low;

    ises_eeprom #(.WRITE_CYCLES(WCY)) dut (
        .mclk(mclk), .rstn(rstn), .supply_above_por(supply),
        .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
        .chip_select_strap_0(strap[0]), .chip_select_strap_1(strap[1]),
        .chip_select_strap_2(strap[2]), .wp_in(wp)
    );
    ises_master m (.mclk(mclk), .sda(sda), .scl(scl), .sda_low(sda_low));

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : give_verdict

    // the device may only move sda while scl is low
    always @(posedge mclk) begin
        oe_q <= sda_oe;
        scl_q <= scl;
        cyc <= cyc + 1;
        // held off in reset: the output may be unknown before the first edge
        if (rstn && scl && scl_q) begin
            check("oe_hold", {7'h0, sda_oe}, {7'h0, oe_q});
        end
        if (cyc == 90000) begin
            n_fail++;
            give_verdict();
        end
    end

    function automatic logic [7:0] dev(input logic [2:0] s, input logic rw);
        return {DEV_TYPE, s, rw};
    endfunction : dev

    task automatic addr_only(input logic [2:0] s, input logic exp);
        logic k;
        m.start();
        m.wbyte(dev(s, 1'b0), k);
        check("dev_ack", {7'h0, k}, {7'h0, exp});
        m.stop();
    endtask : addr_only

    // top two address bits set on purpose: they must be ignored
    task automatic set_addr(input logic [13:0] a);
        logic k;
        m.start();
        m.wbyte(dev(STRAP, 1'b0), k);
        check("dev_ack", {7'h0, k}, 8'h01);
        m.wbyte({2'b11, a[13:8]}, k);
        check("hi_ack", {7'h0, k}, 8'h01);
        m.wbyte(a[7:0], k);
        check("lo_ack", {7'h0, k}, 8'h01);
    endtask : set_addr

    task automatic rd_seq(input logic sel, input logic [13:0] a,
                          input logic [7:0] e[$]);
        logic k;
        logic [7:0] d;
        if (sel) set_addr(a);
        m.start();
        m.wbyte(dev(STRAP, 1'b1), k);
        check("rd_ack", {7'h0, k}, 8'h01);
        foreach (e[i]) begin
            m.rbyte(i < e.size() - 1, d);
            check("rd_data", d, e[i]);
        end
        m.stop();
    endtask : rd_seq

    // busy must refuse a poll at once and release after the write time
    task automatic wr(input logic [13:0] a, input int n, input logic [7:0] b);
        logic k;
        set_addr(a);
        for (int i = 0; i < n; i++) begin
            m.wbyte(b + 8'(i), k);
            check("wr_ack", {7'h0, k}, 8'h01);
        end
        m.stop();
        addr_only(STRAP, 1'b0);
        m.tick(WCY);
        addr_only(STRAP, 1'b1);
    endtask : wr

    task automatic t_no_start();
        logic k;
        m.wbyte(dev(STRAP, 1'b0), k);
        check("no_start", {7'h0, k}, 8'h00);
        m.stop();
    endtask : t_no_start

    task automatic t_power();
        supply <= 1'b0;
        m.tick(10);
        addr_only(STRAP, 1'b0);
        supply <= 1'b1;
        m.tick(10);
        addr_only(STRAP, 1'b1);
    endtask : t_power

    task automatic t_straps();
        logic k;
        m.start();
        m.wbyte({4'h5, STRAP, 1'b0}, k);
        check("type_nak", {7'h0, k}, 8'h00);
        m.stop();
        addr_only(3'h4, 1'b0);
        addr_only(3'h1, 1'b0);
        rd_seq(1'b1, 14'h1234, '{8'hFF});
    endtask : t_straps

    // 65 bytes from byte 62 of page 5: wraps, first location overwritten
    task automatic t_page();
        wr(14'h017E, 65, 8'h00);
        rd_seq(1'b1, 14'h017E, '{8'h40, 8'h01, 8'hFF});
        wr(14'h0140, 2, 8'h80);
        rd_seq(1'b0, 14'h0000, '{8'h04});
        rd_seq(1'b1, 14'h0140, '{8'h80, 8'h81, 8'h04});
    endtask : t_page

    task automatic t_mem_wrap();
        wr(14'h0000, 1, 8'h5A);
        rd_seq(1'b1, 14'h3FFF, '{8'hFF, 8'h5A});
    endtask : t_mem_wrap

    task automatic t_protect();
        logic k;
        wp <= 1'b1;
        set_addr(14'h0000);
        m.wbyte(8'h11, k);
        check("wp_nack", {7'h0, k}, 8'h00);
        m.stop();
        wp <= 1'b0;
        addr_only(STRAP, 1'b1);
        rd_seq(1'b1, 14'h0000, '{8'h5A});
    endtask : t_protect

    initial begin
        rstn = 1'b0;
        supply = 1'b1;
        wp = 1'b0;
        strap = STRAP;
        m.tick(4);
        rstn <= 1'b1;
        m.tick(10);
        check("idle_oe", {7'h0, sda_oe}, 8'h00);
        t_no_start();
        t_power();
        t_straps();
        t_page();
        t_mem_wrap();
        t_protect();
        give_verdict();
    end
endmodule : ises_eeprom_test
